// >>> rtl/vic_ctrl.sv
// Vectored IRQ/FIQ interrupt controller with APB register bank
`timescale 1ns/1ps

// Functional notes
// RL1: Bank at 0xFFFF0000; IRQ group at offset 0x000, FIQ group at 0x100.
// RL2: APB access takes setup plus access phase, two bus cycles.
// RL3: Raw IRQ register 0x004 shows every source level, enabled or not.
// RL4: Raw FIQ register 0x104 shows every source level, enabled or not.
// RL5: Writing 0x00C clears the written bits from IRQ enable at 0x008.
// RL6: Writing 0x10C clears the written bits from FIQ enable at 0x108.
// RL7: Vector base names a 64-byte block of 32 handler pointers.
// RL8: IRQ vector register 0x01C returns handler address of active source.
// RL9: Each source takes a programmable priority level 0 to 7.
// RL10: First priority register packs 4-bit fields, source n at bits 4n+3:4n.
// RL11: Register 0x024 holds priority fields of sources 8 to 15.
// RL12: Register 0x028 holds priority fields of sources 16 to 19.
// RL13: Nesting register 0x030 enables IRQ and FIQ nesting independently.
// RL14: Register 0x034 picks rising, falling or level per external input.
// RL15: Writing 0x038 drops latched edge requests of the written inputs.
// RL16: Register 0x03C reports priority of the last IRQ taken.
// RL17: Register 0x13C reports priority of the last FIQ taken.
// RL18: Active equals raw masked by enable; request high while any active. With nesting on in service, only a smaller level raises it.
// RL19: Highest priority wins; ties go to the lowest source number.
module vic_ctrl
	import vic_pkg::*;
(
	// Clock and reset
	input wire logic CLOCK,
	input wire logic SRST,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Interrupt sources
	input wire logic [VIC_NSRC-1:0] SRC_LEVEL,
	input wire logic [VIC_NEXT-1:0] EXT_PIN,
	// Requests to the core
	output logic IRQ_REQ,
	output logic FIQ_REQ
);

	// --------------------------------------------------------------
	// Helper functions
	// --------------------------------------------------------------

	// Priority field of one source from the three packed registers
	function automatic logic [2:0] prio_of(input logic [95:0] fields,
		input int src);
		logic [3:0] f;
		f = fields[src*VIC_PRIO_W +: VIC_PRIO_W];
		prio_of = f[2:0]; // [RL9]
	endfunction

	// Winning source: smallest level wins, lowest index on a tie
	function automatic logic [5:0] pick_winner(input logic [31:0] act,
		input logic [95:0] fields);
		logic [2:0] best;
		logic [4:0] idx;
		logic found;
		best = 3'h7;
		idx = 5'h00;
		found = 1'b0;
		for (int i = 0; i < VIC_NSRC; i++) begin
			if (act[i] && (!found || prio_of(fields, i) < best)) begin
				best = prio_of(fields, i); // [RL19]
				idx = 5'(i);
				found = 1'b1;
			end
		end
		pick_winner = {found, idx};
	endfunction

	// Handler address inside the 64-byte block
	function automatic logic [31:0] vec_addr(input logic [31:0] base,
		input logic [4:0] idx);
		vec_addr = {base[31:VEC_ALIGN_LSB], idx, 1'b0}; // [RL7]
	endfunction

	// --------------------------------------------------------------
	// State
	// --------------------------------------------------------------
	logic [31:0] irq_en_reg;
	logic [31:0] fiq_en_reg;
	logic [31:0] soft_reg;
	logic [31:0] vec_base_reg;
	logic [95:0] prio_reg;
	logic [31:0] nest_reg;
	logic [31:0] trig_reg;
	logic [VIC_NEXT-1:0] edge_latch_reg;
	logic [VIC_NEXT-1:0] ext_prev_reg;
	logic [3:0] irq_lvl_reg;
	logic [3:0] fiq_lvl_reg;
	logic irq_busy_reg;
	logic fiq_busy_reg;
	logic [31:0] irq_vec_reg;
	logic [31:0] fiq_vec_reg;
	logic [31:0] rdata_reg;
	logic err_reg;
	logic irq_req_reg;
	logic fiq_req_reg;

	// --------------------------------------------------------------
	// Bus decode
	// --------------------------------------------------------------
	logic in_bank;
	logic [11:0] ofs;
	logic setup_ph;
	logic wr_acc;
	logic rd_acc;
	// Bank match on upper address bits [RL1]
	assign in_bank = (PADDR[31:12] == VIC_BANK_HI);
	assign ofs = PADDR[11:0];
	// Data captured in setup, used in access: two bus cycles [RL2]
	assign setup_ph = PSEL && !PENABLE;
	assign wr_acc = PSEL && PENABLE && PWRITE && in_bank;
	assign rd_acc = PSEL && PENABLE && !PWRITE && in_bank;
	// No wait states beyond the access phase
	assign PREADY = 1'b1;

	// --------------------------------------------------------------
	// Source conditioning
	// --------------------------------------------------------------
	logic [VIC_NEXT-1:0] ext_req;
	logic [VIC_NEXT-1:0] edge_hit;
	logic [31:0] raw;
	logic [31:0] irq_act;
	logic [31:0] fiq_act;

	// Edge detection and level selection per external input
	always_comb begin
		for (int e = 0; e < VIC_NEXT; e++) begin
			case (vic_trig_e'(trig_reg[2*e +: 2]))
				VIC_TRIG_RISE: edge_hit[e] = EXT_PIN[e] && !ext_prev_reg[e];
				VIC_TRIG_FALL: edge_hit[e] = !EXT_PIN[e] && ext_prev_reg[e];
				default: edge_hit[e] = 1'b0;
			endcase
			case (vic_trig_e'(trig_reg[2*e +: 2]))
				VIC_TRIG_LEVEL: ext_req[e] = EXT_PIN[e]; // [RL14]
				VIC_TRIG_LOW: ext_req[e] = !EXT_PIN[e]; // [RL14]
				default: ext_req[e] = edge_latch_reg[e]; // [RL14]
			endcase
		end
	end

	// Raw view: hardware levels, software requests, external inputs
	always_comb begin
		raw = RST_WORD;
		raw[VIC_NSRC-1:0] = SRC_LEVEL | soft_reg[VIC_NSRC-1:0];
		raw[VIC_EXT_FIRST +: VIC_NEXT] = raw[VIC_EXT_FIRST +: VIC_NEXT] |
			ext_req;
	end

	// Active views are raw gated by enables [RL18]
	assign irq_act = raw & irq_en_reg;
	assign fiq_act = raw & fiq_en_reg;

	// Pin history for edge detection
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			ext_prev_reg <= '0;
		end else begin
			ext_prev_reg <= EXT_PIN;
		end
	end

	// Edge latches; a new edge outweighs a clear in the same cycle
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			edge_latch_reg <= '0;
		end else begin
			for (int e = 0; e < VIC_NEXT; e++) begin
				if (edge_hit[e]) begin
					edge_latch_reg[e] <= 1'b1;
				end else if (wr_acc && ofs == OFS_EDGE_CLR &&
					PWDATA[VIC_EXT_FIRST + e]) begin
					edge_latch_reg[e] <= 1'b0; // [RL15]
				end
			end
		end
	end

	// --------------------------------------------------------------
	// Arbitration
	// --------------------------------------------------------------
	logic [5:0] irq_win;
	logic [5:0] fiq_win;
	logic [2:0] irq_win_lvl;
	logic [2:0] fiq_win_lvl;
	assign irq_win = pick_winner(irq_act, prio_reg); // [RL19]
	assign fiq_win = pick_winner(fiq_act, prio_reg); // [RL19]
	assign irq_win_lvl = prio_of(prio_reg, int'(irq_win[4:0]));
	assign fiq_win_lvl = prio_of(prio_reg, int'(fiq_win[4:0]));

	// Taking an exception is marked by the core reading the vector
	logic irq_take;
	logic fiq_take;
	assign irq_take = rd_acc && ofs == OFS_IRQ_VEC && irq_win[5];
	assign fiq_take = rd_acc && ofs == OFS_FIQ_VEC && fiq_win[5];

	// Vector registers follow the current winner
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			irq_vec_reg <= RST_WORD;
			fiq_vec_reg <= RST_WORD;
		end else begin
			irq_vec_reg <= irq_win[5] ?
				vec_addr(vec_base_reg, irq_win[4:0]) : RST_WORD; // [RL8]
			fiq_vec_reg <= fiq_win[5] ?
				vec_addr(vec_base_reg, fiq_win[4:0]) : RST_WORD;
		end
	end

	// Level of the IRQ last taken, and in-service tracking
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			irq_lvl_reg <= '0;
			irq_busy_reg <= 1'b0;
		end else if (irq_take) begin
			irq_lvl_reg <= {1'b0, irq_win_lvl}; // [RL16]
			irq_busy_reg <= 1'b1;
		end else if (wr_acc && ofs == OFS_IRQ_LVL) begin
			irq_lvl_reg <= PWDATA[3:0];
			irq_busy_reg <= 1'b0;
		end else if (irq_act == RST_WORD) begin
			irq_busy_reg <= 1'b0;
		end
	end

	// Level of the FIQ last taken; service ends when no FIQ is active
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			fiq_lvl_reg <= '0;
			fiq_busy_reg <= 1'b0;
		end else if (fiq_take) begin
			fiq_lvl_reg <= {1'b0, fiq_win_lvl}; // [RL17]
			fiq_busy_reg <= 1'b1;
		end else if (fiq_act == RST_WORD) begin
			fiq_busy_reg <= 1'b0;
		end
	end

	// Requests: with nesting on, only a strictly smaller level number preempts
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			irq_req_reg <= 1'b0;
			fiq_req_reg <= 1'b0;
		end else begin
			if (nest_reg[NEST_IRQ_BIT] && irq_busy_reg) begin
				irq_req_reg <= irq_win[5] &&
					{1'b0, irq_win_lvl} < irq_lvl_reg; // [RL13]
			end else begin
				irq_req_reg <= irq_win[5]; // [RL18]
			end
			if (nest_reg[NEST_FIQ_BIT] && fiq_busy_reg) begin
				fiq_req_reg <= fiq_win[5] &&
					{1'b0, fiq_win_lvl} < fiq_lvl_reg; // [RL13]
			end else begin
				fiq_req_reg <= fiq_win[5]; // [RL18]
			end
		end
	end
	assign IRQ_REQ = irq_req_reg;
	assign FIQ_REQ = fiq_req_reg;

	// --------------------------------------------------------------
	// Register writes
	// --------------------------------------------------------------

	// Enable set and clear registers
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			irq_en_reg <= RST_WORD;
			fiq_en_reg <= RST_WORD;
		end else if (wr_acc) begin
			if (ofs == OFS_IRQ_EN_SET) begin
				irq_en_reg <= irq_en_reg | PWDATA;
			end else if (ofs == OFS_IRQ_EN_CLR) begin
				irq_en_reg <= irq_en_reg & ~PWDATA; // [RL5]
			end else if (ofs == OFS_FIQ_EN_SET) begin
				fiq_en_reg <= fiq_en_reg | PWDATA;
			end else if (ofs == OFS_FIQ_EN_CLR) begin
				fiq_en_reg <= fiq_en_reg & ~PWDATA; // [RL6]
			end
		end
	end

	// Configuration registers
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			soft_reg <= RST_WORD;
			vec_base_reg <= RST_WORD;
			prio_reg <= '0;
			nest_reg <= RST_WORD;
			trig_reg <= RST_WORD;
		end else if (wr_acc) begin
			if (ofs == OFS_SOFT_CFG) begin
				soft_reg <= PWDATA;
			end else if (ofs == OFS_VEC_BASE) begin
				vec_base_reg <= PWDATA; // [RL7]
			end else if (ofs == OFS_PRIO_LOW) begin
				prio_reg[31:0] <= PWDATA; // [RL10]
			end else if (ofs == OFS_PRIO_MID) begin
				prio_reg[63:32] <= PWDATA; // [RL11]
			end else if (ofs == OFS_PRIO_HIGH) begin
				prio_reg[95:64] <= {16'h0000, PWDATA[15:0]}; // [RL12]
			end else if (ofs == OFS_NEST_CTRL) begin
				nest_reg <= PWDATA; // [RL13]
			end else if (ofs == OFS_EXT_TRIG) begin
				trig_reg <= PWDATA; // [RL14]
			end
		end
	end

	// --------------------------------------------------------------
	// Read path: data captured in the setup phase
	// --------------------------------------------------------------
	logic [31:0] rd_mux;
	logic rd_hit;
	always_comb begin
		rd_mux = RST_WORD;
		rd_hit = 1'b1;
		if (ofs == OFS_IRQ_ACTIVE) begin
			rd_mux = irq_act; // [RL18]
		end else if (ofs == OFS_IRQ_RAW) begin
			rd_mux = raw; // [RL3]
		end else if (ofs == OFS_IRQ_EN_SET) begin
			rd_mux = irq_en_reg;
		end else if (ofs == OFS_IRQ_EN_CLR || ofs == OFS_SOFT_CFG ||
			ofs == OFS_FIQ_EN_CLR || ofs == OFS_RESERVED ||
			ofs == OFS_EDGE_CLR) begin
			rd_mux = RST_WORD;
		end else if (ofs == OFS_VEC_BASE) begin
			rd_mux = vec_base_reg;
		end else if (ofs == OFS_IRQ_VEC) begin
			rd_mux = irq_vec_reg; // [RL8]
		end else if (ofs == OFS_PRIO_LOW) begin
			rd_mux = prio_reg[31:0];
		end else if (ofs == OFS_PRIO_MID) begin
			rd_mux = prio_reg[63:32];
		end else if (ofs == OFS_PRIO_HIGH) begin
			rd_mux = prio_reg[95:64];
		end else if (ofs == OFS_NEST_CTRL) begin
			rd_mux = nest_reg;
		end else if (ofs == OFS_EXT_TRIG) begin
			rd_mux = trig_reg;
		end else if (ofs == OFS_IRQ_LVL) begin
			rd_mux = {28'h0000000, irq_lvl_reg}; // [RL16]
		end else if (ofs == OFS_FIQ_ACTIVE) begin
			rd_mux = fiq_act; // [RL18]
		end else if (ofs == OFS_FIQ_RAW) begin
			rd_mux = raw; // [RL4]
		end else if (ofs == OFS_FIQ_EN_SET) begin
			rd_mux = fiq_en_reg;
		end else if (ofs == OFS_FIQ_VEC) begin
			rd_mux = fiq_vec_reg;
		end else if (ofs == OFS_FIQ_LVL) begin
			rd_mux = {28'h0000000, fiq_lvl_reg}; // [RL17]
		end else begin
			rd_hit = 1'b0;
		end
	end

	// Held through the access phase; refused reads must not leak data
	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			rdata_reg <= RST_WORD;
			err_reg <= 1'b0;
		end else if (setup_ph) begin
			rdata_reg <= (in_bank && rd_hit) ? rd_mux : RST_WORD; // [RL2]
			err_reg <= !(in_bank && rd_hit);
		end
	end
	assign PRDATA = rdata_reg;
	assign PSLVERR = PSEL && PENABLE && err_reg;

endmodule

// >>> rtl/vic_pkg.sv
// Constants for the vectored IRQ/FIQ controller register bank
package vic_pkg;
	// --------------------------------------------------------------
	// Bank placement and sizes
	// --------------------------------------------------------------
	localparam logic [31:0] VIC_BANK_BASE = 32'hFFFF0000;
	localparam logic [19:0] VIC_BANK_HI = 20'hFFFF0;
	localparam int VIC_NSRC = 20;
	localparam int VIC_NEXT = 4;
	localparam int VIC_EXT_FIRST = 12;
	localparam int VIC_PRIO_W = 4;
	localparam int VIC_FIELDS_PER_REG = 8;

	// --------------------------------------------------------------
	// Register offsets (low 12 address bits)
	// --------------------------------------------------------------
	localparam logic [11:0] OFS_IRQ_ACTIVE = 12'h000;
	localparam logic [11:0] OFS_IRQ_RAW = 12'h004;
	localparam logic [11:0] OFS_IRQ_EN_SET = 12'h008;
	localparam logic [11:0] OFS_IRQ_EN_CLR = 12'h00C;
	localparam logic [11:0] OFS_SOFT_CFG = 12'h010;
	localparam logic [11:0] OFS_VEC_BASE = 12'h014;
	localparam logic [11:0] OFS_IRQ_VEC = 12'h01C;
	localparam logic [11:0] OFS_PRIO_LOW = 12'h020;
	localparam logic [11:0] OFS_PRIO_MID = 12'h024;
	localparam logic [11:0] OFS_PRIO_HIGH = 12'h028;
	localparam logic [11:0] OFS_RESERVED = 12'h02C;
	localparam logic [11:0] OFS_NEST_CTRL = 12'h030;
	localparam logic [11:0] OFS_EXT_TRIG = 12'h034;
	localparam logic [11:0] OFS_EDGE_CLR = 12'h038;
	localparam logic [11:0] OFS_IRQ_LVL = 12'h03C;
	localparam logic [11:0] OFS_FIQ_ACTIVE = 12'h100;
	localparam logic [11:0] OFS_FIQ_RAW = 12'h104;
	localparam logic [11:0] OFS_FIQ_EN_SET = 12'h108;
	localparam logic [11:0] OFS_FIQ_EN_CLR = 12'h10C;
	localparam logic [11:0] OFS_FIQ_VEC = 12'h11C;
	localparam logic [11:0] OFS_FIQ_LVL = 12'h13C;

	// --------------------------------------------------------------
	// Field layouts and reset values
	// --------------------------------------------------------------
	localparam int NEST_IRQ_BIT = 0;
	localparam int NEST_FIQ_BIT = 1;
	localparam int VEC_ALIGN_LSB = 6;
	localparam logic [31:0] RST_WORD = 32'h00000000;
	localparam logic [3:0] PRIO_IDLE = 4'hF;

	// External trigger modes, two bits per external input
	typedef enum logic [1:0] {
		VIC_TRIG_LEVEL = 2'h0,
		VIC_TRIG_RISE = 2'h1,
		VIC_TRIG_FALL = 2'h2,
		VIC_TRIG_LOW = 2'h3
	} vic_trig_e;
endpackage

// >>> tb/vic_ctrl_sva.sv
// Port checker for the vectored interrupt controller
`timescale 1ns/1ps
module vic_sva
	import vic_pkg::*;
(
	// Clock and reset
	input wire logic CLOCK,
	input wire logic SRST,
	// Peripheral bus
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// Sources and requests
	input wire logic [VIC_NSRC-1:0] SRC_LEVEL,
	input wire logic [VIC_NEXT-1:0] EXT_PIN,
	input wire logic IRQ_REQ,
	input wire logic FIQ_REQ
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (SRST);
	// Access phase and bank decode
	logic acc;
	logic inb;
	assign acc = PSEL && PENABLE;
	assign inb = PADDR[31:12] == VIC_BANK_HI;
	// ----------
	// Bus checks
	// ----------
	a_ready_high: assert property (PREADY)
		else $error("ready dropped");
	a_err_phase: assert property (PSLVERR |-> acc)
		else $error("error outside access phase");
	a_bank_miss: assert property (PSEL && !PENABLE && !inb
		##1 acc |-> PSLVERR)
		else $error("outside bank not refused");
	a_bank_hit: assert property (PSEL && !PENABLE && inb &&
		(PADDR[11:0] == OFS_IRQ_EN_SET || PADDR[11:0] == OFS_FIQ_EN_SET)
		##1 acc |-> !PSLVERR)
		else $error("enable register refused");
	a_rdata_holds: assert property (acc |=> $stable(PRDATA))
		else $error("read data moved after access");
	a_refused_zero: assert property (acc && !PWRITE && PSLVERR |->
		PRDATA == RST_WORD)
		else $error("refused read not zero");
	a_clear_reads_zero: assert property (acc && !PWRITE && inb &&
		PADDR[11:0] == OFS_IRQ_EN_CLR |-> PRDATA == RST_WORD)
		else $error("write-only register read nonzero");
	// ----------
	// Request checks
	// ----------
	// Extra pin history covers the edge-detect register delay on external inputs
	a_irq_holds: assert property (IRQ_REQ && !PSEL && !$past(PSEL) &&
		$stable(SRC_LEVEL) && $stable(EXT_PIN) &&
		$past(EXT_PIN, 2) == EXT_PIN && $past(EXT_PIN, 3) == EXT_PIN
		|=> IRQ_REQ)
		else $error("irq request dropped without cause");
	a_fiq_holds: assert property (FIQ_REQ && !PSEL && !$past(PSEL) &&
		$stable(SRC_LEVEL) && $stable(EXT_PIN) &&
		$past(EXT_PIN, 2) == EXT_PIN && $past(EXT_PIN, 3) == EXT_PIN
		|=> FIQ_REQ)
		else $error("fiq request dropped without cause");
endmodule

bind vic_ctrl vic_sva u_vic_sva (.CLOCK(CLOCK), .SRST(SRST), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
	.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.SRC_LEVEL(SRC_LEVEL), .EXT_PIN(EXT_PIN), .IRQ_REQ(IRQ_REQ),
	.FIQ_REQ(FIQ_REQ));

// >>> tb/vic_core.sv
// Bus-master model of the processor core
`timescale 1ns/1ps
module vic_core (
	// Clock
	input wire logic CLOCK,
	// Peripheral bus
	output logic PSEL,
	output logic PENABLE,
	output logic PWRITE,
	output logic [31:0] PADDR,
	output logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR
);
	// Idle bus at time zero
	initial begin
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 32'h0;
		PWDATA = 32'h0;
	end
	// Setup cycle, then access held until ready is seen
	task automatic xfer(input logic w, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		@(posedge CLOCK);
		#1;
		PSEL = 1'b1;
		PWRITE = w;
		PADDR = a;
		PWDATA = d;
		@(posedge CLOCK);
		#1;
		PENABLE = 1'b1;
		n = 0;
		@(posedge CLOCK);
		while (PREADY !== 1'b1 && n < 16) begin
			@(posedge CLOCK);
			n++;
		end
		// Answer taken at the edge where ready is seen
		q = PRDATA;
		e = (n < 16) ? PSLVERR : 1'bx; // Timeout shows as unknown
		#1;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		// Released lines stop showing the old value
		PADDR = ~PADDR;
		PWDATA = ~PWDATA;
	endtask
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
module testbench;
	import vic_pkg::*;
	// ----------
	// Signals and bookkeeping
	// ----------
	logic clk, srst, psel, pen, pwr, prdy, perr, irq, fiq, e;
	logic [31:0] padr, pwd, prd, q, base, d, c;
	logic [31:0] en [2];
	logic [19:0] src;
	logic [3:0] ext;
	logic [79:0] pr;
	logic [11:0] g;
	logic [4:0] w;
	int miscompares, samples_checked, seed, h;
	localparam logic [11:0] RZ [21] = '{12'h000, 12'h004, 12'h008,
		12'h00C, 12'h010, 12'h014, 12'h01C, 12'h020, 12'h024, 12'h028,
		12'h02C, 12'h030, 12'h034, 12'h038, 12'h03C, 12'h100, 12'h104,
		12'h108, 12'h10C, 12'h11C, 12'h13C};

	vic_ctrl u_vic_ctrl (.CLOCK(clk), .SRST(srst), .PSEL(psel),
		.PENABLE(pen), .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd),
		.PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .SRC_LEVEL(src),
		.EXT_PIN(ext), .IRQ_REQ(irq), .FIQ_REQ(fiq));
	vic_core u_core (.CLOCK(clk), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(prd),
		.PREADY(prdy), .PSLVERR(perr));

	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ----------
	// Helpers
	// ----------
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk_word(input logic [31:0] gt, input logic [31:0] x);
		samples_checked++;
		if (gt !== x) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, gt, x);
		end
	endtask
	task automatic chk_flag(input logic gt, input logic x);
		samples_checked++;
		if (gt !== x) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, gt, x);
		end
	endtask
	task automatic wr(input logic [11:0] o, input logic [31:0] v);
		u_core.xfer(1'b1, {VIC_BANK_HI, o}, v, q, e);
	endtask
	task automatic rd(input logic [11:0] o, input logic [31:0] x);
		u_core.xfer(1'b0, {VIC_BANK_HI, o}, 32'h0, q, e);
		chk_word(q, x);
		chk_flag(e, 1'b0);
	endtask
	// Lowest level number wins, ties to the lowest source
	function automatic logic [4:0] win(input logic [19:0] a,
		input logic [79:0] p);
		logic [4:0] r;
		logic [3:0] b;
		r = 5'h1F;
		b = 4'hF;
		for (int i = 0; i < 20; i++) begin
			if (a[i] && {1'b0, p[4*i +: 3]} < b) begin
				r = i[4:0];
				b = {1'b0, p[4*i +: 3]};
			end
		end
		return r;
	endfunction
	task automatic final_report();
		$display("checked %0d miscompares %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Hang guard, far beyond the expected run
	initial begin
		#300000;
		miscompares++;
		final_report();
	end
	// ----------
	// Tests
	// ----------
	initial begin
		seed = $urandom(32'h928B58F6);
		srst = 1'b1;
		src = 20'h0;
		ext = 4'h0;
		en = '{32'h0, 32'h0};
		tick(8);
		srst = 1'b0;
		foreach (RZ[i]) rd(RZ[i], RST_WORD);
		$display("test reset_values done");
		u_core.xfer(1'b0, {VIC_BANK_HI, 12'h018}, 32'h0, q, e);
		chk_flag(e, 1'b1);
		chk_word(q, RST_WORD);
		u_core.xfer(1'b1, 32'hFFFF1008, 32'hFFFFF, q, e);
		chk_flag(e, 1'b1);
		rd(OFS_IRQ_EN_SET, RST_WORD);
		$display("test refused_access done");
		for (int k = 0; k < 8; k++) begin
			h = k % 2;
			g = (h == 1) ? 12'h100 : 12'h000;
			d = $urandom & 32'hFFFFF;
			c = $urandom & 32'hFFFFF;
			src = (k < 2) ? 20'hFFFFF : 20'($urandom);
			wr(g + OFS_IRQ_EN_SET, d);
			en[h] = en[h] | d;
			rd(g + OFS_IRQ_EN_SET, en[h]);
			wr(g + OFS_IRQ_EN_CLR, c);
			en[h] = en[h] & ~c;
			rd(g + OFS_IRQ_EN_SET, en[h]);
			rd(g + OFS_IRQ_RAW, {12'h0, src});
			rd(g + OFS_IRQ_ACTIVE, {12'h0, src} & en[h]);
			chk_flag(h == 1 ? fiq : irq, |(src & en[h][19:0]));
		end
		$display("test enables_and_status done");
		src = 20'h0;
		wr(OFS_SOFT_CFG, 32'h00000003);
		rd(OFS_IRQ_RAW, 32'h00000003);
		rd(OFS_SOFT_CFG, RST_WORD);
		wr(OFS_SOFT_CFG, RST_WORD);
		u_core.xfer(1'b0, {20'hFFFF1, OFS_IRQ_EN_SET}, 32'h0, q, e);
		chk_flag(e, 1'b1);
		chk_word(q, RST_WORD);
		base = $urandom & 32'hFFFFFFC0;
		wr(OFS_VEC_BASE, base);
		rd(OFS_VEC_BASE, base);
		wr(OFS_IRQ_EN_SET, 32'hFFFFF);
		wr(OFS_FIQ_EN_SET, 32'hFFFFF);
		for (int k = 0; k < 6; k++) begin
			src = 20'h0;
			pr = 80'({$urandom, $urandom, $urandom}) & {20{4'h7}};
			if (k == 0) pr = 80'h0;
			wr(OFS_PRIO_LOW, pr[31:0]);
			wr(OFS_PRIO_MID, pr[63:32]);
			wr(OFS_PRIO_HIGH, {16'h0, pr[79:64]});
			rd(OFS_PRIO_LOW, pr[31:0]);
			rd(OFS_PRIO_MID, pr[63:32]);
			rd(OFS_PRIO_HIGH, {16'h0, pr[79:64]});
			src = 20'($urandom) | (20'h80000 >> k);
			w = win(src, pr);
			tick(2);
			rd(OFS_IRQ_VEC, {base[31:6], w, 1'b0});
			rd(OFS_IRQ_LVL, {29'h0, pr[4*w +: 3]});
			rd(OFS_FIQ_VEC, {base[31:6], w, 1'b0});
			rd(OFS_FIQ_LVL, {29'h0, pr[4*w +: 3]});
		end
		src = 20'h0;
		$display("test vectors_and_priority done");
		wr(OFS_PRIO_LOW, 32'h00100300);
		for (int n = 1; n >= 0; n--) begin
			// Both nesting bits follow the loop count
			wr(OFS_NEST_CTRL, {30'h0, n[0], n[0]});
			src = 20'h00004;
			tick(2);
			rd(OFS_IRQ_VEC, {base[31:6], 5'h02, 1'b0});
			rd(OFS_FIQ_VEC, {base[31:6], 5'h02, 1'b0});
			tick(3);
			chk_flag(irq, n == 0);
			chk_flag(fiq, n == 0);
			src = 20'h00024;
			tick(3);
			chk_flag(irq, 1'b1);
			chk_flag(fiq, 1'b1);
			src = 20'h0;
			tick(3);
		end
		wr(OFS_IRQ_LVL, 32'h00000005);
		rd(OFS_IRQ_LVL, 32'h00000005);
		$display("test nesting done");
		for (int m = 0; m < 4; m++) begin
			wr(OFS_EXT_TRIG, 32'(m));
			wr(OFS_EDGE_CLR, 32'h1000);
			wr(OFS_EDGE_CLR, 32'h0);
			ext = 4'h1;
			tick(4);
			chk_flag(irq, m < 2);
			ext = 4'h0;
			tick(4);
			chk_flag(irq, m != 0);
			wr(OFS_EDGE_CLR, 32'h1000);
			wr(OFS_EDGE_CLR, 32'h0);
			tick(3);
			chk_flag(irq, m == 3);
		end
		$display("test external_trigger done");
		final_report();
	end
endmodule
